// >>> rtl/bkc_defs.vh
// Constants for the third step-down converter control block
`ifndef BKC_DEFS_VH
`define BKC_DEFS_VH

// =============================================================
// Register offsets
`define BKC_ADDR_W          4
`define BKC_OFF_CTRL        4'h0
`define BKC_OFF_STATUS      4'h1
`define BKC_OFF_LOAD_CFG    4'h2

// =============================================================
// Control register fields
`define BKC_BIT_RSVD        7
`define BKC_BIT_FPWM        6
`define BKC_BIT_EN          5
`define BKC_VSEL_HI         4
`define BKC_VSEL_LO         0

// =============================================================
// Reset values and codes
`define BKC_VSEL_W          5
`define BKC_VSEL_OFF        5'h00
`define BKC_VSEL_1V8        5'h01
`define BKC_VSEL_2V5        5'h0f
`define BKC_VSEL_2V8        5'h15
`define BKC_VSEL_3V3        5'h1f
`define BKC_RST_FPWM        1'b0
`define BKC_RST_EN          1'b1
`define BKC_LOAD_THR_RST    8'h20

// =============================================================
// Voltage decode: millivolts = base + code * step
`define BKC_MV_BASE         12'd1750
`define BKC_MV_STEP         12'd50

// =============================================================
// Power-on sequencing delay
`define BKC_SEQ_DELAY_NS    1000
`define BKC_CLK_PERIOD_NS   10
`define BKC_SEQ_CYCLES      ((`BKC_SEQ_DELAY_NS + `BKC_CLK_PERIOD_NS - 1) / `BKC_CLK_PERIOD_NS)

`endif

// >>> rtl/bkc_mode_sel.v
// Modulation mode selector for the third step-down converter
`timescale 1ns/1ps

module bkc_mode_sel #(
    parameter LOAD_W = 8
) (
    input  wire              i_clk,
    input  wire              i_rst_n,
    input  wire              i_run,
    input  wire              i_force_pwm,
    input  wire [LOAD_W-1:0] i_load,
    input  wire [LOAD_W-1:0] i_threshold,
    output reg               o_pwm
);

    wire auto_pwm;

    // Light load runs pulse-frequency; heavy load runs PWM
    assign auto_pwm = (i_load >= i_threshold);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pwm <= 1'b0;
        end else if (!i_run) begin
            o_pwm <= 1'b0;
        end else begin
            o_pwm <= i_force_pwm | auto_pwm;
        end
    end

endmodule

// >>> rtl/bkc_regulator_ctrl.v
// Control logic for the third step-down converter: register, enable, mode and pulldown
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "bkc_defs.vh"

// Overview of operation
// - Without force-PWM the mode follows the load: PWM at heavy load, PFM at light load.
// - With the force-PWM bit at D6 set the converter runs PWM at every load.
// - Force-PWM is cleared after reset so automatic mode selection is active.
// - Power-on sequencing turns the converter on without any register write.
// - The all-zero voltage code keeps the converter off whatever the enable bit says.
// - While disabled by its enable bit with a nonzero voltage code the output is pulled to ground by the pulldown.
// - With the all-zero voltage code the pulldown is disconnected.
// - The voltage code decodes linearly from 1.80 V at 5'h01 in 0.05 V steps to 3.30 V at 5'h1f.
// - The reset voltage code is a factory choice of 1.8, 2.5, 2.8 or 3.3 V, default 3.3 V.
module bkc_regulator_ctrl #(
    parameter       LOAD_W     = 8,
    parameter [1:0] FACTORY_V  = 2'd3,
    parameter       SEQ_CYCLES = `BKC_SEQ_CYCLES
) (
    input  wire                   i_clk,
    input  wire                   i_reset_n,
    input  wire [`BKC_ADDR_W-1:0] i_addr,
    input  wire [7:0]             i_wdata,
    input  wire                   i_wr,
    input  wire                   i_rd,
    output reg  [7:0]             o_rdata,
    input  wire                   i_seq_start,
    input  wire [LOAD_W-1:0]      i_load_level,
    output reg                    o_conv_on,
    output wire                   o_pwm_mode,
    output reg                    o_pulldown_on,
    output reg  [11:0]            o_vout_mv
);

    // =============================================================
    // Reset release
    reg rst_s1_reg;
    reg rst_n;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // =============================================================
    // Helpers
    function [`BKC_VSEL_W-1:0] factory_code;
        input [1:0] sel;
        begin
            case (sel)
                2'd0:    factory_code = `BKC_VSEL_1V8;
                2'd1:    factory_code = `BKC_VSEL_2V5;
                2'd2:    factory_code = `BKC_VSEL_2V8;
                default: factory_code = `BKC_VSEL_3V3;
            endcase
        end
    endfunction

    function [11:0] code_to_mv;
        input [`BKC_VSEL_W-1:0] code;
        begin
            if (code == `BKC_VSEL_OFF) begin
                code_to_mv = 12'h000;
            end else begin
                code_to_mv = `BKC_MV_BASE + ({7'h00, code} * `BKC_MV_STEP);
            end
        end
    endfunction

    // =============================================================
    // Power-on sequencing
    localparam SEQ_IDLE = 2'd0;
    localparam SEQ_WAIT = 2'd1;
    localparam SEQ_DONE = 2'd2;

    reg [1:0]  seq_state_reg;
    reg [1:0]  seq_state_next;
    reg [15:0] seq_cnt_reg;
    reg [15:0] seq_cnt_next;
    reg        seq_start_s1_reg;
    reg        seq_start_s2_reg;
    reg        seq_start_s3_reg;
    wire       seq_start_seen;

    // Pin input: third stage must agree with the second
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_start_s1_reg <= 1'b0;
            seq_start_s2_reg <= 1'b0;
            seq_start_s3_reg <= 1'b0;
        end else begin
            seq_start_s1_reg <= i_seq_start;
            seq_start_s2_reg <= seq_start_s1_reg;
            seq_start_s3_reg <= seq_start_s2_reg;
        end
    end

    assign seq_start_seen = seq_start_s2_reg & seq_start_s3_reg;

    always @* begin
        seq_state_next = seq_state_reg;
        seq_cnt_next   = seq_cnt_reg;
        case (seq_state_reg)
            SEQ_IDLE: begin
                if (seq_start_seen) begin
                    seq_state_next = SEQ_WAIT;
                    seq_cnt_next   = 16'h0000;
                end
            end
            SEQ_WAIT: begin
                if (seq_cnt_reg >= SEQ_CYCLES - 1) begin
                    seq_state_next = SEQ_DONE;
                end else begin
                    seq_cnt_next = seq_cnt_reg + 16'h0001;
                end
            end
            SEQ_DONE: begin
                seq_state_next = SEQ_DONE;
            end
            default: begin
                seq_state_next = SEQ_IDLE;
            end
        endcase
    end

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_state_reg <= SEQ_IDLE;
            seq_cnt_reg   <= 16'h0000;
        end else begin
            seq_state_reg <= seq_state_next;
            seq_cnt_reg   <= seq_cnt_next;
        end
    end

    // =============================================================
    // Control register
    reg                   fpwm_reg;
    reg                   en_reg;
    reg [`BKC_VSEL_W-1:0] vsel_reg;
    reg [LOAD_W-1:0]      load_thr_reg;
    reg                   vsel_loaded_reg;
    reg                   rst_cap_reg;
    wire                  wr_ctrl;

    assign wr_ctrl = i_wr && (i_addr == `BKC_OFF_CTRL);

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            fpwm_reg        <= `BKC_RST_FPWM;
            en_reg          <= `BKC_RST_EN;
            vsel_reg        <= `BKC_VSEL_3V3;
            load_thr_reg    <= `BKC_LOAD_THR_RST;
            vsel_loaded_reg <= 1'b0;
            rst_cap_reg     <= 1'b1;
        end else begin
            // Factory choice is taken by a clocked load right after release
            rst_cap_reg <= 1'b0;
            if (rst_cap_reg && !vsel_loaded_reg) begin
                vsel_reg        <= factory_code(FACTORY_V);
                vsel_loaded_reg <= 1'b1;
            end
            if (wr_ctrl) begin
                // Bit 7 is never stored
                fpwm_reg <= i_wdata[`BKC_BIT_FPWM];
                en_reg   <= i_wdata[`BKC_BIT_EN];
                vsel_reg <= i_wdata[`BKC_VSEL_HI:`BKC_VSEL_LO];
                vsel_loaded_reg <= 1'b1;
            end
            if (i_wr && (i_addr == `BKC_OFF_LOAD_CFG)) begin
                load_thr_reg <= i_wdata[LOAD_W-1:0];
            end
        end
    end

    // =============================================================
    // Enable, pulldown and voltage outputs
    // Software is expected to set the code before enabling; a same-write
    // of both is also safe since both take effect together.
    wire vsel_zero;
    wire run;

    assign vsel_zero = (vsel_reg == `BKC_VSEL_OFF);
    assign run = en_reg && !vsel_zero && (seq_state_reg == SEQ_DONE);

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_conv_on     <= 1'b0;
            o_pulldown_on <= 1'b0;
            o_vout_mv     <= 12'h000;
        end else begin
            o_conv_on     <= run;
            o_pulldown_on <= !run && !vsel_zero;
            o_vout_mv     <= run ? code_to_mv(vsel_reg) : 12'h000;
        end
    end

    bkc_mode_sel #(
        .LOAD_W (LOAD_W)
    ) u_mode (
        .i_clk       (i_clk),
        .i_rst_n     (rst_n),
        .i_run       (run),
        .i_force_pwm (fpwm_reg),
        .i_load      (i_load_level),
        .i_threshold (load_thr_reg),
        .o_pwm       (o_pwm_mode)
    );

    // =============================================================
    // Read port
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `BKC_OFF_CTRL:     o_rdata <= {1'b0, fpwm_reg, en_reg, vsel_reg};
                `BKC_OFF_STATUS:   o_rdata <= {5'h00, o_pulldown_on, o_pwm_mode, o_conv_on};
                `BKC_OFF_LOAD_CFG: o_rdata <= load_thr_reg;
                default:           o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule

// >>> verif/bkc_regulator_ctrl_chk.sv
// Port-level checker for the step-down converter control block
`timescale 1ns/1ps
`include "bkc_defs.vh"

module bkc_regulator_ctrl_chk (
    input wire logic                   i_clk,
    input wire logic                   i_reset_n,
    input wire logic [`BKC_ADDR_W-1:0] i_addr,
    input wire logic [7:0]             i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic [7:0]             o_rdata,
    input wire logic                   o_conv_on,
    input wire logic                   o_pwm_mode,
    input wire logic                   o_pulldown_on,
    input wire logic [11:0]            o_vout_mv
);
    // =============================================================
    // Helpers
    wire logic wr_ctl = i_wr && (i_addr == `BKC_OFF_CTRL);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // =============================================================
    // Assertions
    a_rsvd_reads_zero: assert property ($past(i_rd) && $past(i_addr) == `BKC_OFF_CTRL |-> !o_rdata[7])
        else $error("reserved control bit read as one");
    a_on_no_pulldown: assert property (o_conv_on |-> !o_pulldown_on)
        else $error("pulldown connected while converter runs");
    a_en_off_pulldown: assert property (wr_ctl && !i_wdata[5] && i_wdata[4:0] != 5'h00
        |-> ##2 (!o_conv_on && o_pulldown_on))
        else $error("disable by enable bit did not connect pulldown");
    a_zero_code_off: assert property (wr_ctl && i_wdata[4:0] == 5'h00 |-> ##2 (!o_conv_on && !o_pulldown_on))
        else $error("zero voltage code left converter or pulldown on");
    a_fpwm_forces: assert property (wr_ctl && i_wdata[6:5] == 2'b11 && i_wdata[4:0] != 5'h00 && o_conv_on
        |-> ##2 o_pwm_mode)
        else $error("force pwm did not select pwm");
    a_pwm_needs_run: assert property (o_pwm_mode |-> o_conv_on)
        else $error("pwm reported while converter off");
    a_vout_scale: assert property ($past(i_rd) && $past(i_addr) == `BKC_OFF_CTRL && o_conv_on
        |-> o_vout_mv == 12'd1750 + 12'd50 * o_rdata[4:0])
        else $error("output voltage does not match code");
    a_vout_off_zero: assert property (!o_conv_on |-> o_vout_mv == 12'h000)
        else $error("voltage reported while converter off");

    c_run_pwm: cover property (o_conv_on && o_pwm_mode);
    c_run_pfm: cover property (o_conv_on && !o_pwm_mode);
    c_pulldown: cover property (o_pulldown_on);
endmodule

bind bkc_regulator_ctrl bkc_regulator_ctrl_chk bkc_regulator_ctrl_chk_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_conv_on(o_conv_on),
    .o_pwm_mode(o_pwm_mode), .o_pulldown_on(o_pulldown_on), .o_vout_mv(o_vout_mv));

// >>> verif/test_bkc_regulator_ctrl.sv
// Testbench for the step-down converter control block
`timescale 1ns/1ps
`include "bkc_defs.vh"

module test_bkc_regulator_ctrl;
    logic                   i_clk = 1'b0;
    logic                   i_reset_n = 1'b0;
    logic [`BKC_ADDR_W-1:0] i_addr = 4'h0;
    logic [7:0]             i_wdata = 8'h00;
    logic                   i_wr = 1'b0;
    logic                   i_rd = 1'b0;
    logic                   i_seq_start = 1'b0;
    logic [7:0]             i_load_level = 8'h00;
    logic [7:0]             o_rdata;
    logic                   o_conv_on;
    logic                   o_pwm_mode;
    logic                   o_pulldown_on;
    logic [11:0]            o_vout_mv;
    int                     err_total = 0;
    int                     comparisons = 0;
    logic [4:0]             codes [4] = '{5'h01, 5'h0f, 5'h15, 5'h1f};

    // Factory code 2.8 V so the factory load differs from the register reset value
    bkc_regulator_ctrl #(.LOAD_W(8), .FACTORY_V(2'd2), .SEQ_CYCLES(2)) bkc_regulator_ctrl_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_seq_start(i_seq_start), .i_load_level(i_load_level), .o_conv_on(o_conv_on),
        .o_pwm_mode(o_pwm_mode), .o_pulldown_on(o_pulldown_on), .o_vout_mv(o_vout_mv));

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    // =============================================================
    // Tasks
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", {4'h0, exp}, {4'h0, o_rdata});
    endtask

    task automatic outs(input logic on, input logic pwm, input logic pd);
        chk("conv_on", {11'h0, on}, {11'h0, o_conv_on});
        chk("pwm_mode", {11'h0, pwm}, {11'h0, o_pwm_mode});
        chk("pulldown", {11'h0, pd}, {11'h0, o_pulldown_on});
    endtask

    task automatic end_of_test;
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_clk);
        err_total++;
        end_of_test();
    end

    // =============================================================
    // Tests
    initial begin
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        cyc(4);
        rd(`BKC_OFF_CTRL, 8'h35);
        outs(1'b0, 1'b0, 1'b1);
        i_seq_start <= 1'b1;
        for (int k = 0; k < 200 && o_conv_on !== 1'b1; k++) cyc(1);
        outs(1'b1, 1'b0, 1'b0);
        chk("vout", 12'd2800, o_vout_mv);
        rd(`BKC_OFF_STATUS, 8'h01);
        rd(`BKC_OFF_LOAD_CFG, 8'h20);
        i_load_level <= 8'h40;
        cyc(3);
        outs(1'b1, 1'b1, 1'b0);
        i_load_level <= 8'h00;
        wr(`BKC_OFF_CTRL, 8'h75);
        cyc(3);
        outs(1'b1, 1'b1, 1'b0);
        for (int k = 0; k < 4; k++) begin
            wr(`BKC_OFF_CTRL, {3'b101, codes[k]});
            cyc(3);
            chk("vout", 12'd1750 + 12'd50 * codes[k], o_vout_mv);
            rd(`BKC_OFF_CTRL, {3'b001, codes[k]});
        end
        outs(1'b1, 1'b0, 1'b0);
        wr(`BKC_OFF_CTRL, 8'h1f);
        cyc(3);
        outs(1'b0, 1'b0, 1'b1);
        rd(`BKC_OFF_STATUS, 8'h04);
        wr(`BKC_OFF_CTRL, 8'h20);
        cyc(3);
        outs(1'b0, 1'b0, 1'b0);
        rd(4'hf, 8'h00);
        wr(`BKC_OFF_LOAD_CFG, 8'h08);
        rd(`BKC_OFF_LOAD_CFG, 8'h08);
        rd(`BKC_OFF_STATUS, 8'h00);
        end_of_test();
    end
endmodule
